// ### verilog/dacq_consts.vh
// Constants for the digitizer acquisition and trigger controller
`ifndef DACQ_CONSTS_VH
`define DACQ_CONSTS_VH
// Register offsets
`define DACQ_REG_CTRL    4'h0
`define DACQ_REG_DIV     4'h1
`define DACQ_REG_TRIG    4'h2
`define DACQ_REG_PRECNT  4'h3
`define DACQ_REG_POSTCNT 4'h4
`define DACQ_REG_DELAY   4'h5
`define DACQ_REG_RTCNT   4'h6
`define DACQ_REG_CMD     4'h7
`define DACQ_REG_STATUS  4'h8
`define DACQ_REG_STORED  4'h9
// Control field positions
`define DACQ_CTRL_TB_LSB   0
`define DACQ_CTRL_CH0EN    2
`define DACQ_CTRL_CH1EN    3
`define DACQ_CTRL_RANGE    4
`define DACQ_CTRL_PINGPONG 5
`define DACQ_CTRL_MODE_LSB 6
`define DACQ_CTRL_IGNEARLY 8
`define DACQ_CTRL_RETRIG   9
// Trigger field positions
`define DACQ_TRG_SRC_LSB 0
`define DACQ_TRG_ANCH    2
`define DACQ_TRG_NEGSLP  3
`define DACQ_TRG_EXTFALL 4
`define DACQ_TRG_LVL_LSB 8
// Timebase codes
`define DACQ_TB_INT  2'h0
`define DACQ_TB_EXT  2'h1
`define DACQ_TB_SYNC 2'h2
// Trigger sources
`define DACQ_SRC_SW   2'h0
`define DACQ_SRC_ANA  2'h1
`define DACQ_SRC_EXT  2'h2
`define DACQ_SRC_SYNC 2'h3
// Trigger modes
`define DACQ_MODE_POST  2'h0
`define DACQ_MODE_PRE   2'h1
`define DACQ_MODE_MID   2'h2
`define DACQ_MODE_DELAY 2'h3
// Reset values
`define DACQ_DIV_RST   24'h000001
`define DACQ_LVL_ZERO  8'h80
`define DACQ_DELAY_RST 32'h00000001
`endif

// ### verilog/dacq_acq_trigger_ctrl.v
// Acquisition, sample clock and trigger controller for a two-channel digitizer
`timescale 1ns/100ps
`include "dacq_consts.vh"
module dacq_acq_trigger_ctrl #(
   parameter DIVW = 24,
   parameter CNTW = 32,
   parameter ADCW = 14
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Register port
   input wire [3:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdData,
   // Timebase ticks, one-cycle pulses per timebase period
   input wire tbIntTick,
   input wire tbExtTick,
   input wire tbSyncTick,
   // Converter data, valid on sample strobe
   input wire [ADCW-1:0] firstInputChannelData,
   input wire [ADCW-1:0] secondInputChannelData,
   // External triggers
   input wire triggerConnectorPin,
   input wire boardSyncInterfaceTrig,
   // Converter clocks and front end
   output reg adcClkFirst,
   output reg adcClkSecond,
   output reg rangeOneVolt,
   output reg timebaseExtSel,
   // Storage side
   output reg storeFirst,
   output reg storeSecond,
   output reg [ADCW-1:0] storeFirstData,
   output reg [ADCW-1:0] storeSecondData,
   output reg trigEvent,
   output reg acqDone
);

   localparam ST_IDLE = 5'h01;
   localparam ST_PRE = 5'h02;
   localparam ST_WAIT = 5'h04;
   localparam ST_DELAY = 5'h08;
   localparam ST_POST = 5'h10;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [9:0] ctrl_r;
   reg [DIVW-1:0] div_r;
   reg [15:0] trig_r;
   reg [CNTW-1:0] preCnt_r;
   reg [CNTW-1:0] postCnt_r;
   reg [CNTW-1:0] delay_r;
   reg [15:0] rtCnt_r;
   reg [DIVW-1:0] divCnt_r;
   reg sampleTick_r;
   reg pingSel_r;
   reg [4:0] state_r;
   reg [CNTW-1:0] cnt_r;
   reg [CNTW-1:0] preHave_r;
   reg [15:0] recLeft_r;
   reg [CNTW-1:0] stored_r;
   reg swPend_r;
   reg extPrev_r;
   reg syncPrev_r;
   reg [7:0] prevSample_r;
   reg prevValid_r;
   reg done_r;

   wire [1:0] tbSel = ctrl_r[`DACQ_CTRL_TB_LSB+1:`DACQ_CTRL_TB_LSB];
   wire [1:0] mode = ctrl_r[`DACQ_CTRL_MODE_LSB+1:`DACQ_CTRL_MODE_LSB];
   wire pingPong = ctrl_r[`DACQ_CTRL_PINGPONG];
   wire ignEarly = ctrl_r[`DACQ_CTRL_IGNEARLY];
   wire reTrig = ctrl_r[`DACQ_CTRL_RETRIG];
   wire [1:0] trgSrc = trig_r[`DACQ_TRG_SRC_LSB+1:`DACQ_TRG_SRC_LSB];
   wire [7:0] level = trig_r[`DACQ_TRG_LVL_LSB+7:`DACQ_TRG_LVL_LSB];
   wire cmdWr = regWr && (regAddr == `DACQ_REG_CMD);
   wire startCmd = cmdWr && regWrData[0];
   wire abortCmd = cmdWr && regWrData[1];

   // ------------------------------------------------------------
   // Register write and read port
   // ------------------------------------------------------------
   // Configuration writes
   always @(posedge clk) begin
      if (!reset_n) begin
         ctrl_r <= 10'h00C;
         div_r <= `DACQ_DIV_RST;
         trig_r <= {`DACQ_LVL_ZERO, 8'h00};
         preCnt_r <= 32'h00000001;
         postCnt_r <= 32'h00000001;
         delay_r <= `DACQ_DELAY_RST;
         rtCnt_r <= 16'h0001;
      end else if (regWr) begin
         case (regAddr)
            `DACQ_REG_CTRL: ctrl_r <= regWrData[9:0];
            `DACQ_REG_DIV: div_r <= (regWrData[DIVW-1:0] == 0) ?
               `DACQ_DIV_RST : regWrData[DIVW-1:0];
            `DACQ_REG_TRIG: trig_r <= regWrData[15:0];
            `DACQ_REG_PRECNT: preCnt_r <= regWrData;
            `DACQ_REG_POSTCNT: postCnt_r <= regWrData;
            `DACQ_REG_DELAY: delay_r <= (regWrData == 0) ?
               `DACQ_DELAY_RST : regWrData;
            `DACQ_REG_RTCNT: rtCnt_r <= regWrData[15:0];
            default: ;
         endcase
      end
   end

   // Read data, one cycle after strobe; unmapped reads zero
   always @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            `DACQ_REG_CTRL: regRdData <= {22'h000000, ctrl_r};
            `DACQ_REG_DIV: regRdData <= {8'h00, div_r};
            `DACQ_REG_TRIG: regRdData <= {16'h0000, trig_r};
            `DACQ_REG_PRECNT: regRdData <= preCnt_r;
            `DACQ_REG_POSTCNT: regRdData <= postCnt_r;
            `DACQ_REG_DELAY: regRdData <= delay_r;
            `DACQ_REG_RTCNT: regRdData <= {16'h0000, rtCnt_r};
            `DACQ_REG_STATUS: regRdData <= {26'h0000000, state_r, done_r};
            `DACQ_REG_STORED: regRdData <= stored_r;
            default: regRdData <= 32'h00000000;
         endcase
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Timebase select and sample clock divider
   // ------------------------------------------------------------
   // timebase multiplexer
   wire tbTick = (tbSel == `DACQ_TB_EXT) ? tbExtTick :
      (tbSel == `DACQ_TB_SYNC) ? tbSyncTick : tbIntTick;

   always @(posedge clk) begin
      if (!reset_n) begin
         divCnt_r <= {DIVW{1'b0}};
         sampleTick_r <= 1'b0;
      end else begin
         sampleTick_r <= 1'b0;
         if (tbTick) begin
            if (divCnt_r + 24'h000001 >= div_r) begin
               divCnt_r <= {DIVW{1'b0}};
               sampleTick_r <= 1'b1;
            end else begin
               divCnt_r <= divCnt_r + 24'h000001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Converter clocking, dual or ping-pong
   // ------------------------------------------------------------
   // alternate converters in ping-pong
   always @(posedge clk) begin
      if (!reset_n) begin
         adcClkFirst <= 1'b0;
         adcClkSecond <= 1'b0;
         pingSel_r <= 1'b0;
         rangeOneVolt <= 1'b0;
         timebaseExtSel <= 1'b0;
      end else begin
         rangeOneVolt <= ctrl_r[`DACQ_CTRL_RANGE];
         // external source kept for the sine input path
         timebaseExtSel <= (tbSel == `DACQ_TB_EXT);
         if (pingPong) begin
            adcClkFirst <= sampleTick_r && !pingSel_r;
            adcClkSecond <= sampleTick_r && pingSel_r;
            if (sampleTick_r)
               pingSel_r <= !pingSel_r;
         end else begin
            adcClkFirst <= sampleTick_r;
            adcClkSecond <= sampleTick_r;
            pingSel_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Trigger detection
   // ------------------------------------------------------------
   // analog trigger channel select
   wire [7:0] anaNow = trig_r[`DACQ_TRG_ANCH] ?
      secondInputChannelData[ADCW-1:ADCW-8] :
      firstInputChannelData[ADCW-1:ADCW-8];
   // offset binary code compares directly with sample
   wire nowAbove = anaNow > level;
   wire nowBelow = anaNow < level;
   wire wasAbove = prevSample_r > level;
   wire wasBelow = prevSample_r < level;
   wire posHit = prevValid_r && wasBelow && nowAbove;
   wire negHit = prevValid_r && wasAbove && nowBelow;
   wire anaHit = sampleTick_r &&
      (trig_r[`DACQ_TRG_NEGSLP] ? negHit : posHit);
   wire extHit = trig_r[`DACQ_TRG_EXTFALL] ?
      (extPrev_r && !triggerConnectorPin) :
      (!extPrev_r && triggerConnectorPin);
   wire syncHit = !syncPrev_r && boardSyncInterfaceTrig;
   reg trigRaw;
   always @* begin
      case (trgSrc)
         `DACQ_SRC_SW: trigRaw = swPend_r;
         `DACQ_SRC_ANA: trigRaw = anaHit;
         `DACQ_SRC_EXT: trigRaw = extHit;
         `DACQ_SRC_SYNC: trigRaw = syncHit;
         default: trigRaw = 1'b0;
      endcase
   end

   // Edge history and analog sample history
   always @(posedge clk) begin
      if (!reset_n) begin
         extPrev_r <= 1'b0;
         syncPrev_r <= 1'b0;
         prevSample_r <= `DACQ_LVL_ZERO;
         prevValid_r <= 1'b0;
      end else begin
         extPrev_r <= triggerConnectorPin;
         syncPrev_r <= boardSyncInterfaceTrig;
         if (state_r == ST_IDLE) begin
            prevValid_r <= 1'b0;
         end else if (sampleTick_r) begin
            prevSample_r <= anaNow;
            prevValid_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Acquisition sequencer
   // ------------------------------------------------------------
   wire preFull = preHave_r >= preCnt_r;
   wire inPreMode = (mode == `DACQ_MODE_PRE) || (mode == `DACQ_MODE_MID);
   // early trigger ignored when option set
   wire trigOk = trigRaw && (preFull || !ignEarly);
   wire storing = sampleTick_r &&
      ((state_r == ST_PRE) || (state_r == ST_POST));

   always @(posedge clk) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         cnt_r <= {CNTW{1'b0}};
         preHave_r <= {CNTW{1'b0}};
         recLeft_r <= 16'h0000;
         stored_r <= {CNTW{1'b0}};
         swPend_r <= 1'b0;
         done_r <= 1'b0;
         trigEvent <= 1'b0;
         acqDone <= 1'b0;
      end else begin
         trigEvent <= 1'b0;
         acqDone <= done_r;
         if (storing)
            stored_r <= stored_r + 32'h00000001;
         case (state_r)
            ST_IDLE: begin
               swPend_r <= 1'b0;
               if (startCmd) begin
                  // Done clears on start; set wins elsewhere
                  done_r <= 1'b0;
                  stored_r <= {CNTW{1'b0}};
                  preHave_r <= {CNTW{1'b0}};
                  recLeft_r <= (rtCnt_r == 0 || !reTrig) ?
                     16'h0001 : rtCnt_r;
                  swPend_r <= 1'b1;
                  state_r <= inPreMode ? ST_PRE : ST_WAIT;
               end
            end
            ST_PRE: begin
               // acquire until trigger, ring keeps latest
               if (sampleTick_r && !preFull)
                  preHave_r <= preHave_r + 32'h00000001;
               swPend_r <= 1'b0;
               if (trigOk) begin
                  trigEvent <= 1'b1;
                  if (mode == `DACQ_MODE_MID) begin
                     cnt_r <= postCnt_r;
                     state_r <= ST_POST;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_WAIT: begin
               swPend_r <= 1'b0;
               if (trigRaw) begin
                  trigEvent <= 1'b1;
                  if (mode == `DACQ_MODE_DELAY) begin
                     cnt_r <= delay_r;
                     state_r <= ST_DELAY;
                  end else begin
                     cnt_r <= postCnt_r;
                     state_r <= ST_POST;
                  end
               end
            end
            ST_DELAY: begin
               if (tbTick) begin
                  if (cnt_r <= 32'h00000001) begin
                     cnt_r <= postCnt_r;
                     state_r <= ST_POST;
                  end else begin
                     cnt_r <= cnt_r - 32'h00000001;
                  end
               end
            end
            ST_POST: begin
               if (sampleTick_r) begin
                  if (cnt_r <= 32'h00000001) begin
                     if (recLeft_r > 16'h0001 && !inPreMode) begin
                        recLeft_r <= recLeft_r - 16'h0001;
                        state_r <= ST_WAIT;
                     end else begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                     end
                  end else begin
                     cnt_r <= cnt_r - 32'h00000001;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         if (abortCmd)
            state_r <= ST_IDLE;
      end
   end

   // ------------------------------------------------------------
   // Storage strobes
   // ------------------------------------------------------------
   // per-channel enables gate storage
   always @(posedge clk) begin
      if (!reset_n) begin
         storeFirst <= 1'b0;
         storeSecond <= 1'b0;
         storeFirstData <= {ADCW{1'b0}};
         storeSecondData <= {ADCW{1'b0}};
      end else begin
         storeFirst <= storing && ctrl_r[`DACQ_CTRL_CH0EN];
         storeSecond <= storing && !pingPong &&
            ctrl_r[`DACQ_CTRL_CH1EN];
         storeFirstData <= (pingPong && pingSel_r) ?
            secondInputChannelData : firstInputChannelData;
         storeSecondData <= secondInputChannelData;
      end
   end

endmodule

// ### dv/dacq_adc_model.sv
// Converter and timebase model feeding the acquisition controller
`timescale 1ns/100ps
module dacq_adc_model (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Converter clock
   input wire adcClkFirst,
   // Timebase ticks
   output reg tbIntTick,
   output reg tbExtTick,
   output reg tbSyncTick,
   // Converter outputs
   output reg [13:0] firstData,
   output wire [13:0] secondData
);
   reg [4:0] phase_r;
   // Second converter sees the mirror image
   assign secondData = ~firstData;
   always @(posedge clk) begin
      phase_r <= (!reset_n || phase_r == 5'h1D) ? 5'h00 : phase_r + 5'h01;
      tbIntTick <= reset_n && phase_r[0];
      tbExtTick <= reset_n && (phase_r % 3 == 0);
      tbSyncTick <= reset_n && (phase_r % 5 == 0);
      // Ramp moves the upper byte by 16 per conversion
      if (!reset_n)
         firstData <= 14'h0000;
      else if (adcClkFirst)
         firstData <= firstData + 14'h0400;
   end
endmodule

// ### dv/dacq_acq_trigger_ctrl_props.sv
// Property checker for the acquisition and trigger controller
`timescale 1ns/100ps
`include "dacq_consts.vh"
module dacq_acq_trigger_ctrl_chk (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Register port
   input wire [3:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   // Timebase ticks
   input wire tbIntTick,
   input wire tbExtTick,
   input wire tbSyncTick,
   // Controller outputs
   input wire adcClkFirst,
   input wire adcClkSecond,
   input wire rangeOneVolt,
   input wire timebaseExtSel,
   input wire storeSecond,
   input wire trigEvent,
   input wire acqDone
);
   reg [9:0] ctrlSh_r;
   reg [1:0] srcSh_r;
   wire ctrlWr;
   wire startWr;
   wire selTick;
   // Decode of the writes the checks follow
   assign ctrlWr = regWr && regAddr == `DACQ_REG_CTRL;
   assign startWr = regWr && regAddr == `DACQ_REG_CMD && regWrData[0];
   assign selTick = ctrlSh_r[1:0] == `DACQ_TB_INT ? tbIntTick :
      ctrlSh_r[1:0] == `DACQ_TB_EXT ? tbExtTick : tbSyncTick;
   // Shadow of control and trigger source
   always @(posedge clk) begin
      if (!reset_n) begin
         ctrlSh_r <= 10'h00C;
         srcSh_r <= 2'h0;
      end else begin
         if (ctrlWr)
            ctrlSh_r <= regWrData[9:0];
         if (regWr && regAddr == `DACQ_REG_TRIG)
            srcSh_r <= regWrData[1:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Start with software source in post or delay mode
   sequence swStart;
      startWr && srcSh_r == `DACQ_SRC_SW && ctrlSh_r[7] == ctrlSh_r[6];
   endsequence
   sequence swFire;
      ##2 trigEvent;
   endsequence
   chk_sw_fire: assert property (swStart |-> swFire)
      else $error("software trigger late or missing");
   chk_trig_single: assert property (trigEvent |=> !trigEvent)
      else $error("trigger event longer than one cycle");
   chk_done_hold: assert property (acqDone && !startWr
      && !$past(startWr) |=> acqDone)
      else $error("done flag dropped without start");
   chk_start_clears: assert property (startWr |=> ##1 !acqDone)
      else $error("done flag kept after start");
   chk_dual_clocks: assert property (!ctrlSh_r[5] && ctrlSh_r[3]
      && !$past(ctrlWr) && adcClkFirst |-> adcClkSecond)
      else $error("converters not clocked together");
   chk_ping_alt: assert property (ctrlSh_r[5] && !$past(ctrlWr) |->
      !(adcClkFirst && adcClkSecond) && !storeSecond)
      else $error("ping-pong clocks overlap or second stored");
   chk_tick_lead: assert property (adcClkFirst || adcClkSecond
      |-> $past(selTick, 2))
      else $error("converter clock without timebase tick");
   chk_range_out: assert property (!$past(ctrlWr)
      |-> rangeOneVolt == ctrlSh_r[4])
      else $error("range output differs from setting");
   chk_tb_select: assert property (!$past(ctrlWr)
      |-> timebaseExtSel == (ctrlSh_r[1:0] == `DACQ_TB_EXT))
      else $error("timebase select output differs from setting");
endmodule
bind dacq_acq_trigger_ctrl dacq_acq_trigger_ctrl_chk
   dacq_acq_trigger_ctrl_chk_inst (
   .clk(clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .tbIntTick(tbIntTick),
   .tbExtTick(tbExtTick), .tbSyncTick(tbSyncTick),
   .adcClkFirst(adcClkFirst), .adcClkSecond(adcClkSecond),
   .rangeOneVolt(rangeOneVolt), .timebaseExtSel(timebaseExtSel),
   .storeSecond(storeSecond), .trigEvent(trigEvent), .acqDone(acqDone)
);

// ### dv/dacq_acq_trigger_ctrl_tb.sv
// Self-checking bench for the acquisition and trigger controller
`timescale 1ns/100ps
`include "dacq_consts.vh"
module dacq_acq_trigger_ctrl_tb;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg [3:0] regAddr = 4'h0;
   reg [31:0] regWrData = 32'h0;
   reg regWr = 1'b0;
   reg regRd = 1'b0;
   reg pinLvl = 1'b0;
   reg syncLvl = 1'b0;
   wire [31:0] regRdData;
   wire tbInt, tbExt, tbSync, adcA, adcB, storeA, storeB, trigEv, acqDone;
   wire [13:0] dataA, dataB, sdA, sdB;
   int err_total = 0;
   int total_checks = 0;
   int nA, nB, nT, i, k;
   time tA, tPrev, tT, tS;
   reg [7:0] trigByte;
   reg [68:0] row;
   // Rows: write flag, address, write data, expected read
   localparam logic [68:0] ROWS [0:13] = '{
      {1'b0, 4'h0, 32'h0, 32'h0000000C}, {1'b0, 4'h1, 32'h0, 32'h1},
      {1'b0, 4'h2, 32'h0, 32'h00008000}, {1'b0, 4'h4, 32'h0, 32'h1},
      {1'b0, 4'h5, 32'h0, 32'h1}, {1'b0, 4'h6, 32'h0, 32'h1},
      {1'b0, 4'h8, 32'h0, 32'h2}, {1'b0, 4'h9, 32'h0, 32'h0},
      {1'b0, 4'hA, 32'h0, 32'h0}, {1'b1, 4'h1, 32'h0, 32'h1},
      {1'b1, 4'h5, 32'h0, 32'h1}, {1'b1, 4'h1, 32'hFF000005, 32'h5},
      {1'b1, 4'hB, 32'h5, 32'h0}, {1'b1, 4'h2, 32'hA51D, 32'hA51D}};
   dacq_adc_model dacq_adc_model_inst (.clk(clk), .reset_n(reset_n),
      .adcClkFirst(adcA), .tbIntTick(tbInt), .tbExtTick(tbExt),
      .tbSyncTick(tbSync), .firstData(dataA), .secondData(dataB));
   dacq_acq_trigger_ctrl dacq_acq_trigger_ctrl_inst (.clk(clk),
      .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .tbIntTick(tbInt), .tbExtTick(tbExt), .tbSyncTick(tbSync),
      .firstInputChannelData(dataA), .secondInputChannelData(dataB),
      .triggerConnectorPin(pinLvl), .boardSyncInterfaceTrig(syncLvl),
      .adcClkFirst(adcA), .adcClkSecond(adcB), .rangeOneVolt(),
      .timebaseExtSel(), .storeFirst(storeA), .storeSecond(storeB),
      .storeFirstData(sdA), .storeSecondData(sdB), .trigEvent(trigEv),
      .acqDone(acqDone));
   // Clock at 10 MHz
   always #50 clk = ~clk;
   // Event counters and time stamps
   always @(posedge clk) begin
      if (storeA) begin
         nA = nA + 1;
         tPrev = tA;
         tA = $time;
         if (tS == 0)
            tS = $time;
      end
      if (storeB)
         nB = nB + 1;
      if (trigEv) begin
         nT = nT + 1;
         tT = $time;
         trigByte = dataA[13:6];
      end
   end
   // ------------------------------
   // Checking and bus tasks
   // ------------------------------
   task cmp(input [31:0] g, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         regAddr <= a;
         regWrData <= d;
         regWr <= 1'b1;
         @(posedge clk);
         regWr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge clk);
         regRd <= 1'b0;
         #1 cmp(regRdData, e);
         @(posedge clk);
      end
   endtask
   task acq(input [31:0] ctrl, input [31:0] trg, input [31:0] div,
      input [31:0] post);
      begin
         wr(`DACQ_REG_CTRL, ctrl);
         wr(`DACQ_REG_TRIG, trg);
         wr(`DACQ_REG_DIV, div);
         wr(`DACQ_REG_POSTCNT, post);
         nA = 0;
         nB = 0;
         nT = 0;
         tS = 0;
         wr(`DACQ_REG_CMD, 32'h1);
      end
   endtask
   task wait_done;
      begin
         // Let the done flag of the previous run drop after the start
         @(posedge clk);
         i = 0;
         while (acqDone !== 1'b1 && i < 5000) begin
            @(posedge clk);
            i = i + 1;
         end
         cmp({31'h0, acqDone}, 32'h1);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_total);
         if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Watchdog against a hung sequence
   initial begin
      #5000000;
      err_total = err_total + 1;
      close_out;
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 14; k = k + 1) begin
         row = ROWS[k];
         if (row[68])
            wr(row[67:64], row[63:32]);
         rd(row[67:64], row[31:0]);
      end
      // Each timebase with divisor three, software trigger
      for (k = 0; k < 3; k = k + 1) begin
         acq(32'h00C | k | (k & 1) << 4, 32'h8000, 32'h3, 32'h2);
         wait_done;
         cmp(nB, 2);
         cmp(tS > tT, 1);
         cmp(tA - tPrev, 300 * (k == 0 ? 2 : k == 1 ? 3 : 5));
         rd(`DACQ_REG_STATUS, 32'h3);
      end
      // Ping-pong on the first channel
      acq(32'h024, 32'h8000, 32'h1, 32'h4);
      wait_done;
      cmp(nA, 4);
      // Re-trigger from rising, sync and falling sources
      wr(`DACQ_REG_RTCNT, 32'h3);
      for (k = 0; k < 3; k = k + 1) begin
         pinLvl <= (k == 2);
         acq(32'h20C, 32'h8000 | (k == 1 ? 3 : 2) | (k == 2) << 4, 32'h1,
            32'h2);
         for (i = 0; i < 6; i = i + 1) begin
            repeat (30) @(posedge clk);
            if (i == 4)
               cmp({31'h0, acqDone}, 32'h0);
            if (k == 1)
               syncLvl <= ~syncLvl;
            else
               pinLvl <= ~pinLvl;
         end
         wait_done;
         cmp(nT, 3);
         cmp(nA, 6);
      end
      // Analog level crossing, both slopes
      for (k = 0; k < 2; k = k + 1) begin
         acq(32'h00C, 32'h4801 | k << 3, 32'h1, 32'h1);
         wait_done;
         cmp(nT, 1);
         cmp(trigByte, k ? 8'h00 : 8'h50);
      end
      // Early trigger in pre and middle modes, kept or ignored
      wr(`DACQ_REG_PRECNT, 32'h8);
      pinLvl <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
         acq((k < 2 ? 32'h04C : 32'h08C) | (k & 1) << 8, 32'h8002, 32'h1,
            32'h3);
         repeat (2) @(posedge clk);
         pinLvl <= 1'b1;
         repeat (80) @(posedge clk);
         pinLvl <= 1'b0;
         repeat (2) @(posedge clk);
         pinLvl <= 1'b1;
         wait_done;
         pinLvl <= 1'b0;
         cmp(nT, 1);
         cmp(nA >= (k < 2 ? 8 : 11), k & 1);
      end
      // Delay of twenty timebase periods
      wr(`DACQ_REG_DELAY, 32'h14);
      acq(32'h0CC, 32'h8000, 32'h1, 32'h1);
      wait_done;
      cmp(tS - tT >= 4000 && tS - tT <= 5000, 1);
      close_out;
   end
endmodule
